// ### core/rmrc_pkg.sv
// Overview of operation
// - Sense enable bit switches temperature circuit.
// - Range bit selects high or low output.
// - Gain code 11 fourfold, 10 twofold.
// - Ready flag set after reference settles.
// - Regulator mode chosen automatically from state.
// - Awake with fast clock gives high mode.
// - Awake with low-bias oscillator gives low mode.
// - Sleep with select clear gives low mode.
// - Sleep, select set, idle gives power-save.
// - Brownout, oscillator, self-write, conversion force low in sleep.
// - Supply below core level forces tracking mode.
// - Upper six regulator control bits read zero.
package rmrc_pkg;
    localparam logic [11:0] REF_CTRL_ADDR = 12'h000;
    localparam logic [11:0] REG_CTRL_ADDR = 12'h004;
    localparam int REF_EN_BIT = 7;
    localparam int REF_RDY_BIT = 6;
    localparam int TS_EN_BIT = 5;
    localparam int TS_RNG_BIT = 4;
    localparam int SLEEP_SEL_BIT = 1;
    localparam logic [7:0] REF_CTRL_RESET = 8'h00;
    localparam logic [7:0] REG_CTRL_RESET = 8'h01;
    localparam int SETTLE_NS = 25000;
    localparam int CLK_NS = 50;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {RMRC_GAIN_OFF, RMRC_GAIN_X1, RMRC_GAIN_X2, RMRC_GAIN_X4} rmrc_gain_t;
    typedef enum logic [1:0] {RMRC_MODE_HIGH, RMRC_MODE_LOW, RMRC_MODE_SAVE, RMRC_MODE_TRACK}
        rmrc_mode_t;
    typedef enum logic [1:0] {RMRC_BIAS_HP, RMRC_BIAS_MP, RMRC_BIAS_LP, RMRC_BIAS_EC} rmrc_bias_t;

    typedef struct packed {
        logic sleeping;
        rmrc_bias_t bias;
        logic hfOscActive;
        logic periphActive;
        logic brownoutEn;
        logic selfWrite;
        logic convActive;
        logic supplyLow;
    } rmrc_status_t;

    typedef struct packed {
        logic refEnable;
        rmrc_gain_t gain;
        logic tempEnable;
        logic tempHighRange;
        rmrc_mode_t regMode;
    } rmrc_analog_t;
endpackage : rmrc_pkg

// ### core/rmrc_regulator_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module rmrc_regulator_ctrl (
    input wire logic sys_clk, // System clock, 20 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic clkEn, // Freezes all state while low.
    input wire logic [11:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [11:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire rmrc_pkg::rmrc_status_t status, // Operating state of the device.
    output rmrc_pkg::rmrc_analog_t analogCtrl // Controls to the analog blocks.
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic hitAddr(input logic [11:0] addr, input logic [11:0] base);
        hitAddr = (addr[11:2] == base[11:2]);
    endfunction : hitAddr

    logic [7:0] refCtrl_q;
    logic [7:0] refCtrl_d;
    logic [1:0] regCtrl_q;
    logic [1:0] regCtrl_d;
    logic [15:0] settleCnt_q;
    logic [15:0] settleCnt_d;
    logic refReady_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [11:0] awAddr_q;
    logic [7:0] wByte_q;
    logic wLane_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic rValid_q;
    logic [31:0] rData_q;
    logic [1:0] rResp_q;
    rmrc_pkg::rmrc_analog_t analog_q;
    rmrc_pkg::rmrc_analog_t analog_d;
    rmrc_pkg::rmrc_mode_t mode;
    logic awReady_q;
    logic wReady_q;
    logic arReady_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Address and data are taken independently; the write happens once both are held.
    wire awTake = clkEn && s_axi_awvalid && awReady_q;
    wire wTake = clkEn && s_axi_wvalid && wReady_q;
    wire doWrite = clkEn && awHeld_q && wHeld_q && !bValid_q;
    wire wrRef = doWrite && wLane_q && hitAddr(awAddr_q, rmrc_pkg::REF_CTRL_ADDR);
    wire wrReg = doWrite && wLane_q && hitAddr(awAddr_q, rmrc_pkg::REG_CTRL_ADDR);
    wire wrHit = hitAddr(awAddr_q, rmrc_pkg::REF_CTRL_ADDR)
        || hitAddr(awAddr_q, rmrc_pkg::REG_CTRL_ADDR);
    wire arTake = clkEn && s_axi_arvalid && arReady_q;
    wire rdRef = hitAddr(s_axi_araddr, rmrc_pkg::REF_CTRL_ADDR);
    wire rdReg = hitAddr(s_axi_araddr, rmrc_pkg::REG_CTRL_ADDR);
    // Hold state after this edge; readiness is derived from it so that ready is a flop output.
    wire awHeldNext = doWrite ? 1'b0 : (awTake || awHeld_q);
    wire wHeldNext = doWrite ? 1'b0 : (wTake || wHeld_q);
    wire bValidNext = doWrite || (bValid_q && !s_axi_bready);
    wire rValidNext = arTake || (rValid_q && !s_axi_rready);

    // Bits 3:2 and the ready bit are not writable and read from their own sources.
    assign refCtrl_d = wrRef ? {wByte_q[7], 1'b0, wByte_q[5:4], 2'b00, wByte_q[1:0]} : refCtrl_q;
    // Only bits 1:0 exist; upper six bits are dropped on write.
    assign regCtrl_d = wrReg ? wByte_q[1:0] : regCtrl_q;

    wire [7:0] refRead = {refCtrl_q[7], refReady_q, refCtrl_q[5:4], 2'b00, refCtrl_q[1:0]};
    wire [7:0] regRead = {6'h00, regCtrl_q};
    wire [31:0] rdWord = rdRef ? {24'h000000, refRead} : rdReg ? {24'h000000, regRead} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Settling counter restarts on every enable; disabling drops the ready flag on the next clock.
    wire refOn = refCtrl_q[rmrc_pkg::REF_EN_BIT];
    assign settleCnt_d = !refOn ? 16'h0000
        : (settleCnt_q == 16'(rmrc_pkg::SETTLE_CYCLES)) ? settleCnt_q : settleCnt_q + 16'h0001;
    wire refSettled = refOn && (settleCnt_q == 16'(rmrc_pkg::SETTLE_CYCLES));

    ////////////////////////////////////////////////////////////////////////////////
    // The reserved bit 0 is stored but never steers the mode; keeping it set is up to software.
    wire sleepSel = regCtrl_q[rmrc_pkg::SLEEP_SEL_BIT];
    wire forceLow = status.brownoutEn || status.hfOscActive || status.selfWrite
        || status.convActive;
    // Tracking wins over everything because regulation cannot hold below the core level.
    assign mode = status.supplyLow ? rmrc_pkg::RMRC_MODE_TRACK
        : !status.sleeping ? ((status.bias == rmrc_pkg::RMRC_BIAS_LP) ? rmrc_pkg::RMRC_MODE_LOW
            : rmrc_pkg::RMRC_MODE_HIGH)
        : !sleepSel ? rmrc_pkg::RMRC_MODE_LOW
        : (forceLow || status.periphActive) ? rmrc_pkg::RMRC_MODE_LOW
        : rmrc_pkg::RMRC_MODE_SAVE;

    assign analog_d.refEnable = refOn;
    assign analog_d.gain = rmrc_pkg::rmrc_gain_t'(refCtrl_q[1:0]);
    assign analog_d.tempEnable = refCtrl_q[rmrc_pkg::TS_EN_BIT];
    assign analog_d.tempHighRange = refCtrl_q[rmrc_pkg::TS_RNG_BIT];
    assign analog_d.regMode = mode;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            refCtrl_q <= rmrc_pkg::REF_CTRL_RESET;
            regCtrl_q <= rmrc_pkg::REG_CTRL_RESET[1:0];
            settleCnt_q <= 16'h0000;
            refReady_q <= 1'b0;
            analog_q <= '0;
        end
        else if (clkEn)
        begin
            refCtrl_q <= refCtrl_d;
            regCtrl_q <= regCtrl_d;
            settleCnt_q <= settleCnt_d;
            refReady_q <= refSettled;
            analog_q <= analog_d;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 12'h000;
            wByte_q <= 8'h00;
            wLane_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= rmrc_pkg::RESP_OKAY;
        end
        else if (clkEn)
        begin
            if (awTake)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake)
            begin
                wHeld_q <= 1'b1;
                wByte_q <= s_axi_wdata[7:0];
                wLane_q <= s_axi_wstrb[0];
            end
            if (doWrite)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= wrHit ? rmrc_pkg::RESP_OKAY : rmrc_pkg::RESP_SLVERR;
            end
            else if (bValid_q && s_axi_bready)
            begin
                bValid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= rmrc_pkg::RESP_OKAY;
        end
        else if (clkEn)
        begin
            if (arTake)
            begin
                rValid_q <= 1'b1;
                rData_q <= rdWord;
                rResp_q <= (rdRef || rdReg) ? rmrc_pkg::RESP_OKAY : rmrc_pkg::RESP_SLVERR;
            end
            else if (rValid_q && s_axi_rready)
            begin
                rValid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign analogCtrl = analog_q;

    // Ready strobes are registered so every output comes from a flip-flop.
    // A request seen while ready is low simply waits; nothing is dropped.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            arReady_q <= 1'b0;
        end
        else if (clkEn)
        begin
            awReady_q <= !awHeldNext && !bValidNext;
            wReady_q <= !wHeldNext && !bValidNext;
            arReady_q <= !rValidNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_ts_enable;
        @(posedge sys_clk) disable iff (!reset_n)
        clkEn ##1 1'b1 |-> analogCtrl.tempEnable == $past(refCtrl_q[rmrc_pkg::TS_EN_BIT]);
    endproperty
    a_ts_enable: assert property (p_ts_enable) else $error("sensor enable mismatch");

    property p_ts_range;
        @(posedge sys_clk) disable iff (!reset_n)
        clkEn ##1 1'b1 |-> analogCtrl.tempHighRange == $past(refCtrl_q[rmrc_pkg::TS_RNG_BIT]);
    endproperty
    a_ts_range: assert property (p_ts_range) else $error("sensor range mismatch");

    property p_gain;
        @(posedge sys_clk) disable iff (!reset_n)
        clkEn ##1 1'b1 |-> analogCtrl.gain == $past(refCtrl_q[1:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain mismatch");

    property p_ready_off;
        @(posedge sys_clk) disable iff (!reset_n)
        !refOn && clkEn |=> !refReady_q;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready while disabled");

    property p_track;
        @(posedge sys_clk) disable iff (!reset_n)
        status.supplyLow |-> mode == rmrc_pkg::RMRC_MODE_TRACK;
    endproperty
    a_track: assert property (p_track) else $error("tracking not chosen");

    property p_awake_low;
        @(posedge sys_clk) disable iff (!reset_n)
        !status.supplyLow && !status.sleeping && status.bias == rmrc_pkg::RMRC_BIAS_LP
            |-> mode == rmrc_pkg::RMRC_MODE_LOW;
    endproperty
    a_awake_low: assert property (p_awake_low) else $error("low bias not low mode");

    property p_force_low;
        @(posedge sys_clk) disable iff (!reset_n)
        !status.supplyLow && status.sleeping && forceLow |-> mode == rmrc_pkg::RMRC_MODE_LOW;
    endproperty
    a_force_low: assert property (p_force_low) else $error("override missed");

    property p_upper_zero;
        @(posedge sys_clk) disable iff (!reset_n)
        arTake && rdReg |=> s_axi_rdata[7:2] == 6'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

    property p_awake_high;
        @(posedge sys_clk) disable iff (!reset_n)
        !status.supplyLow && !status.sleeping && status.bias != rmrc_pkg::RMRC_BIAS_LP
            |-> mode == rmrc_pkg::RMRC_MODE_HIGH;
    endproperty
    a_awake_high: assert property (p_awake_high) else $error("not high mode");

    property p_sleep_low;
        @(posedge sys_clk) disable iff (!reset_n)
        !status.supplyLow && status.sleeping && !sleepSel |-> mode == rmrc_pkg::RMRC_MODE_LOW;
    endproperty
    a_sleep_low: assert property (p_sleep_low) else $error("sleep not low mode");

    property p_save;
        @(posedge sys_clk) disable iff (!reset_n)
        !status.supplyLow && status.sleeping && sleepSel && !forceLow && !status.periphActive
            |-> mode == rmrc_pkg::RMRC_MODE_SAVE;
    endproperty
    a_save: assert property (p_save) else $error("power-save missed");

    property p_mode_reg;
        @(posedge sys_clk) disable iff (!reset_n)
        clkEn |=> analogCtrl.regMode == $past(mode);
    endproperty
    a_mode_reg: assert property (p_mode_reg) else $error("mode not delivered");

    property p_ready_set;
        @(posedge sys_clk) disable iff (!reset_n)
        clkEn && refOn && settleCnt_q == 16'(rmrc_pkg::SETTLE_CYCLES)
            |=> refReady_q;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_ref_on;
        @(posedge sys_clk) disable iff (!reset_n)
        clkEn |=> analogCtrl.refEnable == $past(refOn);
    endproperty
    a_ref_on: assert property (p_ref_on) else $error("reference enable mismatch");

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake checks; one write and one read are in flight at most.
    // The responses must stand until taken, or the master would lose them.
    property p_bvalid_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

    property p_rvalid_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");

    property p_one_write;
        @(posedge sys_clk) disable iff (!reset_n)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_one_write: assert property (p_one_write) else $error("ready during response");

    property p_slverr;
        @(posedge sys_clk) disable iff (!reset_n)
        arTake && !rdRef && !rdReg |=> s_axi_rresp == rmrc_pkg::RESP_SLVERR;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read accepted");

    property p_wr_ok;
        @(posedge sys_clk) disable iff (!reset_n)
        doWrite && wrHit |=> s_axi_bvalid && s_axi_bresp == rmrc_pkg::RESP_OKAY;
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("mapped write refused");

    c_save: cover property (@(posedge sys_clk) mode == rmrc_pkg::RMRC_MODE_SAVE);
    c_ready: cover property (@(posedge sys_clk) refReady_q);
    c_write: cover property (@(posedge sys_clk) wrReg);
    c_track: cover property (@(posedge sys_clk) mode == rmrc_pkg::RMRC_MODE_TRACK);
    c_high: cover property (@(posedge sys_clk) mode == rmrc_pkg::RMRC_MODE_HIGH);

endmodule : rmrc_regulator_ctrl
`default_nettype wire

// ### bench/rmrc_regulator_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rmrc_regulator_ctrl_tb;
    localparam int LIMIT = 20000;
    localparam logic [33:0] ALL = '1;
    logic sys_clk, reset_n, clkEn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    rmrc_pkg::rmrc_status_t status, st;
    rmrc_pkg::rmrc_analog_t analogCtrl;
    logic [67:0] notes[$];
    logic [67:0] note;
    logic [31:0] rnd;
    int mismatches, compares, cycles;
    ////////////////////////////////////////////////////////////////////////////////////////
    rmrc_regulator_ctrl u_rmrc_regulator_ctrl (.sys_clk(sys_clk), .reset_n(reset_n),
        .clkEn(clkEn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .status(status), .analogCtrl(analogCtrl));
    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic rmrc_pkg::rmrc_mode_t emode(input rmrc_pkg::rmrc_status_t s,
        input logic sel);
        if (s.supplyLow) return rmrc_pkg::RMRC_MODE_TRACK;
        if (!s.sleeping && s.bias == rmrc_pkg::RMRC_BIAS_LP) return rmrc_pkg::RMRC_MODE_LOW;
        if (!s.sleeping) return rmrc_pkg::RMRC_MODE_HIGH;
        if (sel && !(s.hfOscActive | s.periphActive | s.brownoutEn | s.selfWrite | s.convActive))
            return rmrc_pkg::RMRC_MODE_SAVE;
        return rmrc_pkg::RMRC_MODE_LOW;
    endfunction : emode

    task automatic check(input string nm, input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // Each bus task first lets an edge pass, so a release and the next raise never share a step.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", {32'h0, s_axi_bresp}, {32'h0, rmrc_pkg::RESP_OKAY});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m);
        @(posedge sys_clk);
        notes.push_back({m, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
        if (s_axi_rvalid && s_axi_rready)
        begin
            note = notes.pop_front();
            check("read", {s_axi_rresp, s_axi_rdata} & note[67:34], note[33:0]);
        end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        {reset_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        clkEn = 1'b1;
        s_axi_wstrb = 4'hf;
        status = '0;
        rnd = 32'h25bb;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(rmrc_pkg::REF_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 24'h0, rmrc_pkg::REF_CTRL_RESET}, ALL);
        rd(rmrc_pkg::REG_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 24'h0, rmrc_pkg::REG_CTRL_RESET}, ALL);
        $display("test reset values done");
        wr(rmrc_pkg::REG_CTRL_ADDR, 32'hffff_ffff);
        rd(rmrc_pkg::REG_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 32'h0000_0003}, ALL);
        wr(rmrc_pkg::REG_CTRL_ADDR, 32'h0000_0001);
        rd(rmrc_pkg::REG_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 32'h0000_0001}, ALL);
        $display("test regulator control done");
        for (int g = 0; g < 4; g++)
        begin
            wr(rmrc_pkg::REF_CTRL_ADDR, {26'h0, g[1], g[1] ^ g[0], 2'b11, g[1:0]});
            rd(rmrc_pkg::REF_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 26'h0, g[1], g[1] ^ g[0], 2'b00,
                g[1:0]}, ALL);
            check("gain", {32'h0, analogCtrl.gain}, {32'h0, g[1:0]});
            check("tempOn", {33'h0, analogCtrl.tempEnable}, {33'h0, g[1]});
            check("range", {33'h0, analogCtrl.tempHighRange}, {33'h0, g[1] ^ g[0]});
        end
        $display("test reference fields done");
        // The ready bit is written as one too, which must have no effect since it is read only.
        wr(rmrc_pkg::REF_CTRL_ADDR, 32'h0000_00c3);
        rd(rmrc_pkg::REF_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 32'h0000_0083}, ALL);
        repeat (rmrc_pkg::SETTLE_CYCLES + 10) @(posedge sys_clk);
        rd(rmrc_pkg::REF_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 32'h0000_00c3}, ALL);
        check("refOn", {33'h0, analogCtrl.refEnable}, 34'h1);
        wr(rmrc_pkg::REF_CTRL_ADDR, 32'h0000_0043);
        rd(rmrc_pkg::REF_CTRL_ADDR, {rmrc_pkg::RESP_OKAY, 32'h0000_0003}, ALL);
        $display("test reference ready done");
        // Override inputs are ANDed pairs, supply low an ANDed triple, so that the power-save case is still reached.
        for (int i = 0; i < 64; i++)
        begin
            if (i % 16 == 0) wr(rmrc_pkg::REG_CTRL_ADDR, {30'h0, i[4], 1'b1});
            rnd = lfsr(rnd);
            st = {rnd[0], rnd[2:1], rnd[3] & rnd[4], rnd[5] & rnd[6], rnd[7] & rnd[8],
                rnd[9] & rnd[10], rnd[11] & rnd[12], rnd[13] & rnd[14] & rnd[15]};
            @(posedge sys_clk);
            status <= st;
            repeat (3) @(posedge sys_clk);
            check("mode", {32'h0, analogCtrl.regMode}, {32'h0, emode(st, i[4])});
        end
        $display("test regulator modes done");
        // A low enable must freeze the delivered mode although the operating state moves on.
        @(posedge sys_clk);
        clkEn <= 1'b0;
        status <= ~st;
        repeat (3) @(posedge sys_clk);
        check("frozen", {32'h0, analogCtrl.regMode}, {32'h0, emode(st, 1'b1)});
        clkEn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("thawed", {32'h0, analogCtrl.regMode}, {32'h0, emode(~st, 1'b1)});
        $display("test clock enable done");
        rd(12'h008, {rmrc_pkg::RESP_SLVERR, 32'h0}, ALL);
        $display("test unmapped read done");
        results();
    end
endmodule : rmrc_regulator_ctrl_tb
`default_nettype wire
